// ---- hw/aft_hop_mem.sv ----
// hop address store with registered read data
module aft_hop_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] raddr,
  output logic [15:0] rdata_q
);
  logic [15:0] mem [0:aft_pkg::HOP_DEPTH-1];

  always_ff @(posedge aclk) begin
    if (we && 32'(waddr) < aft_pkg::HOP_DEPTH) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 16'h0000;
    end else if (32'(raddr) < aft_pkg::HOP_DEPTH) begin
      rdata_q <= mem[raddr];
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule : aft_hop_mem

// ---- hw/aft_pkg.sv ----
// constants, frame layout, register map and state types of the api frame block
package aft_pkg;
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] T_ROUTE = 8'h21;
  localparam logic [7:0] T_ATCMD = 8'h08;
  localparam logic [7:0] T_ATQUE = 8'h09;
  localparam logic [7:0] T_ATRSP = 8'h88;
  localparam logic [7:0] T_MSTAT = 8'h8a;
  localparam logic [7:0] CSUM_TOTAL = 8'hff;
  // frame offsets as counted from the delimiter
  localparam int FRAME_HDR = 3;
  localparam int OFF_FID = 4;
  localparam int OFF_CMD = 5;
  localparam int OFF_STATUS = 7;
  localparam int OFF_PARAM = 7;
  localparam int OFF_DST16 = 13;
  localparam int OFF_CNT = 16;
  localparam int OFF_HOP = 17;
  // same offsets as payload indices
  localparam logic [7:0] IX_FID = 8'(OFF_FID - FRAME_HDR);
  localparam logic [7:0] IX_CMD = 8'(OFF_CMD - FRAME_HDR);
  localparam logic [7:0] IX_STATUS = 8'(OFF_STATUS - FRAME_HDR);
  localparam logic [7:0] IX_PARAM = 8'(OFF_PARAM - FRAME_HDR);
  localparam logic [7:0] IX_DST16 = 8'(OFF_DST16 - FRAME_HDR);
  localparam logic [7:0] IX_CNT = 8'(OFF_CNT - FRAME_HDR);
  localparam logic [7:0] IX_HOP = 8'(OFF_HOP - FRAME_HDR);
  localparam logic [7:0] ROUTE_TABLE = 8'd40;
  localparam logic [7:0] MAX_HOPS = 8'd11;
  localparam int HOP_DEPTH = 11;
  // module status codes
  localparam logic [7:0] ST_HW_RESET = 8'h00;
  localparam logic [7:0] ST_WDOG_RESET = 8'h01;
  localparam logic [7:0] ST_JOINED = 8'h02;
  localparam logic [7:0] ST_DISASSOC = 8'h03;
  localparam logic [7:0] ST_COORD_UP = 8'h06;
  localparam logic [7:0] ST_KEY_UPDATE = 8'h07;
  localparam logic [7:0] ST_SUPPLY_LIMIT = 8'h0d;
  localparam logic [7:0] ST_CFG_IN_JOIN = 8'h11;
  localparam logic [7:0] ST_STACK_ERR = 8'h80;
  // command outcome codes
  localparam logic [2:0] RSP_OK = 3'h0;
  localparam logic [2:0] RSP_ERROR = 3'h1;
  localparam logic [2:0] RSP_BAD_CMD = 3'h2;
  localparam logic [2:0] RSP_BAD_PARAM = 3'h3;
  localparam logic [2:0] RSP_TX_FAIL = 3'h4;
  localparam logic [2:0] RSP_MAX_DATA = 3'h4;
  // register byte addresses
  localparam logic [7:0] A_IRQ_STS = 8'h00;
  localparam logic [7:0] A_IRQ_MASK = 8'h04;
  localparam logic [7:0] A_REQ_INFO = 8'h08;
  localparam logic [7:0] A_REQ_PARAM = 8'h0c;
  localparam logic [7:0] A_RESP = 8'h10;
  localparam logic [7:0] A_RESP_DATA = 8'h14;
  localparam logic [7:0] A_MSTAT = 8'h18;
  localparam logic [7:0] A_ROUTE = 8'h1c;
  localparam logic [7:0] A_HOP = 8'h20;
  // interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IB_AT_REQ = 0;
  localparam int IB_ROUTE_OK = 1;
  localparam int IB_ROUTE_DROP = 2;
  localparam int IB_CSUM_ERR = 3;
  localparam int IB_TX_DONE = 4;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_LENH = 5'b00010, RX_LENL = 5'b00100,
    RX_DATA = 5'b01000, RX_CSUM = 5'b10000
  } aft_rx_st_t;
  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001, TX_DELIM = 6'b000010, TX_LENH = 6'b000100,
    TX_LENL = 6'b001000, TX_PAY = 6'b010000, TX_CSUM = 6'b100000
  } aft_tx_st_t;
endpackage : aft_pkg

// ---- hw/aft_responder.sv ----
// api frame responder: request parsing, response framing, register slave
module aft_responder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  aft_rx_if rxb ();
  aft_rx_parser u_rx (.aclk(aclk), .aresetn(aresetn), .rx_valid(rx_valid),
                      .rx_data(rx_data), .pb(rxb.src));

  logic [7:0] p_type_q, s_fid_q, s_c0_q, s_c1_q, s_cnt_q, hop_hi_q;
  logic [31:0] s_par_q;
  logic [15:0] s_dst_q;
  logic s_has_par_q;
  logic [7:0] req_fid_q, req_c0_q, req_c1_q, rt_cnt_q;
  logic [31:0] req_par_q;
  logic [15:0] rt_dst_q;
  logic req_has_par_q, req_que_q, req_pend_q, rt_vld_q;
  logic at_frm, rt_frm, at_commit, rt_commit, rt_bad, hop_we;
  logic [7:0] hop_off;
  logic [15:0] hop_rd;
  localparam int IRQ_W_L = aft_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] sts_q, mask_q, sts_set;
  logic [3:0] hop_sel_q;
  logic [31:0] rsp_data_q, wd, rd_d, dsh_q;
  logic [2:0] rsp_st_q, rsp_len_q, n_len;
  logic rsp_more_q, rsp_pend_q, mst_pend_q;
  logic [7:0] mst_code_q, x_code_q, plen_q, idx_q, csum_q, pay_b;
  logic kind_q, tx_start, ld, do_wr, wr_resp, wr_mst, rd_ok;
  logic [7:0] wa;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  aft_pkg::aft_tx_st_t st_q;

  assign at_frm = (p_type_q == aft_pkg::T_ATCMD) ||
                  (p_type_q == aft_pkg::T_ATQUE);
  assign rt_frm = (p_type_q == aft_pkg::T_ROUTE);
  assign at_commit = rxb.frame_end && rxb.frame_ok && at_frm;
  assign rt_commit = rxb.frame_end && rxb.frame_ok && rt_frm;
  assign rt_bad = (s_cnt_q == 8'h00) || (s_cnt_q > aft_pkg::ROUTE_TABLE) ||
                  (s_cnt_q > aft_pkg::MAX_HOPS);

  // incoming frame field capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_type_q <= 8'h00;
      s_fid_q <= 8'h00;
      s_c0_q <= 8'h00;
      s_c1_q <= 8'h00;
      s_par_q <= 32'h00000000;
      s_has_par_q <= 1'b0;
      s_dst_q <= 16'h0000;
      s_cnt_q <= 8'h00;
    end else if (rxb.pay_valid) begin
      if (rxb.pay_idx == 8'h00) begin
        p_type_q <= rxb.pay_byte;
        s_has_par_q <= 1'b0;
        s_par_q <= 32'h00000000;
      end else if (rxb.pay_idx == aft_pkg::IX_FID) begin
        s_fid_q <= rxb.pay_byte;
      end else if (at_frm) begin
        if (rxb.pay_idx == aft_pkg::IX_CMD) s_c0_q <= rxb.pay_byte;
        else if (rxb.pay_idx == aft_pkg::IX_CMD + 8'h01) begin
          s_c1_q <= rxb.pay_byte;
        end else if (rxb.pay_idx >= aft_pkg::IX_PARAM) begin
          s_has_par_q <= 1'b1;
          s_par_q <= {s_par_q[23:0], rxb.pay_byte};
        end
      end else if (rt_frm) begin
        if (rxb.pay_idx == aft_pkg::IX_DST16) begin
          s_dst_q[15:8] <= rxb.pay_byte;
        end else if (rxb.pay_idx == aft_pkg::IX_DST16 + 8'h01) begin
          s_dst_q[7:0] <= rxb.pay_byte;
        end else if (rxb.pay_idx == aft_pkg::IX_CNT) begin
          s_cnt_q <= rxb.pay_byte;
        end
      end
    end
  end

  // hop store: entry 0 is the destination neighbour, as sent
  assign hop_off = rxb.pay_idx - aft_pkg::IX_HOP;
  assign hop_we = rxb.pay_valid && rt_frm && rxb.pay_idx >= aft_pkg::IX_HOP &&
                  hop_off[0] && (hop_off[7:1] < aft_pkg::MAX_HOPS[6:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn) hop_hi_q <= 8'h00;
    else if (rxb.pay_valid && !hop_off[0]) hop_hi_q <= rxb.pay_byte;
  end
  aft_hop_mem u_hops (.aclk(aclk), .aresetn(aresetn), .we(hop_we),
                      .waddr(hop_off[4:1]), .wdata({hop_hi_q, rxb.pay_byte}),
                      .raddr(hop_sel_q), .rdata_q(hop_rd));

  // committed request and route
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {req_fid_q, req_c0_q, req_c1_q} <= 24'h000000;
      req_par_q <= 32'h00000000;
      req_has_par_q <= 1'b0;
      req_que_q <= 1'b0;
      rt_dst_q <= 16'h0000;
      rt_cnt_q <= 8'h00;
      rt_vld_q <= 1'b0;
    end else begin
      if (at_commit) begin
        req_fid_q <= s_fid_q;
        req_c0_q <= s_c0_q;
        req_c1_q <= s_c1_q;
        req_par_q <= s_par_q;
        req_has_par_q <= s_has_par_q;
        req_que_q <= (p_type_q == aft_pkg::T_ATQUE);
      end
      if (rxb.pay_valid && rxb.pay_idx == 8'h00 &&
          rxb.pay_byte == aft_pkg::T_ROUTE) rt_vld_q <= 1'b0;
      else if (rt_commit && !rt_bad) begin
        rt_vld_q <= 1'b1;
        rt_cnt_q <= s_cnt_q;
        rt_dst_q <= s_dst_q;
      end
    end
  end

  // axi write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aft_pkg::RESP_OKAY;
      wa <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wa <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa[7:2] > aft_pkg::A_HOP[7:2] || wa[1:0] != 2'b00) ?
                       aft_pkg::RESP_DECERR : aft_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wd = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_resp = do_wr && wa == aft_pkg::A_RESP;
  assign wr_mst = do_wr && wa == aft_pkg::A_MSTAT;

  // software settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= aft_pkg::MASK_RST;
      rsp_data_q <= 32'h00000000;
      hop_sel_q <= 4'h0;
      mst_code_q <= aft_pkg::ST_HW_RESET;
      rsp_st_q <= aft_pkg::RSP_OK;
      rsp_len_q <= 3'h0;
      rsp_more_q <= 1'b0;
    end else if (do_wr) begin
      unique case (wa)
        aft_pkg::A_IRQ_MASK: mask_q <= wd[IRQ_W_L-1:0];
        aft_pkg::A_RESP_DATA: rsp_data_q <= wd;
        aft_pkg::A_HOP: hop_sel_q <= wd[3:0];
        aft_pkg::A_MSTAT: mst_code_q <= wd[7:0];
        aft_pkg::A_RESP: begin
          rsp_st_q <= wd[2:0];
          rsp_len_q <= wd[5:3];
          rsp_more_q <= wd[6];
        end
        default: ;
      endcase
    end
  end

  // pending frames; a set in the cycle of its clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_pend_q <= 1'b1;
      rsp_pend_q <= 1'b0;
      req_pend_q <= 1'b0;
    end else begin
      mst_pend_q <= wr_mst || (mst_pend_q && !(tx_start && mst_pend_q));
      rsp_pend_q <= (wr_resp && req_pend_q && req_fid_q != 8'h00) ||
                    (rsp_pend_q && !(tx_start && !mst_pend_q));
      req_pend_q <= at_commit ||
                    (req_pend_q && !(wr_resp && !wd[6]));
    end
  end

  // outgoing frame builder
  assign tx_start = (st_q == aft_pkg::TX_IDLE) && (mst_pend_q || rsp_pend_q);
  assign ld = !tx_valid || tx_ready;
  assign n_len = (rsp_len_q > aft_pkg::RSP_MAX_DATA) ? aft_pkg::RSP_MAX_DATA
                                                       : rsp_len_q;
  always_comb begin
    pay_b = dsh_q[31:24];
    if (kind_q) begin
      pay_b = (idx_q == 8'h00) ? aft_pkg::T_MSTAT : x_code_q;
    end else if (idx_q == 8'h00) pay_b = aft_pkg::T_ATRSP;
    else if (idx_q == aft_pkg::IX_FID) pay_b = req_fid_q;
    else if (idx_q == aft_pkg::IX_CMD) pay_b = req_c0_q;
    else if (idx_q == aft_pkg::IX_CMD + 8'h01) pay_b = req_c1_q;
    else if (idx_q == aft_pkg::IX_STATUS) pay_b = {5'h00, rsp_st_q};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= aft_pkg::TX_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      {kind_q, x_code_q, plen_q, idx_q, csum_q} <= 33'h000000000;
      dsh_q <= 32'h00000000;
    end else begin
      if (tx_valid && tx_ready) tx_valid <= 1'b0;
      unique case (st_q)
        aft_pkg::TX_IDLE: if (tx_start) begin
          kind_q <= mst_pend_q;
          x_code_q <= mst_code_q;
          plen_q <= mst_pend_q ? 8'h02 :
                    (req_has_par_q ? 8'h05 : 8'h05 + {5'h00, n_len});
          dsh_q <= rsp_data_q << {3'h4 - n_len, 3'h0};
          st_q <= aft_pkg::TX_DELIM;
        end
        aft_pkg::TX_DELIM: if (ld) begin
          {tx_valid, tx_data} <= {1'b1, aft_pkg::DELIM};
          st_q <= aft_pkg::TX_LENH;
        end
        aft_pkg::TX_LENH: if (ld) begin
          {tx_valid, tx_data} <= 9'h100;
          st_q <= aft_pkg::TX_LENL;
        end
        aft_pkg::TX_LENL: if (ld) begin
          {tx_valid, tx_data} <= {1'b1, plen_q};
          {idx_q, csum_q} <= 16'h0000;
          st_q <= aft_pkg::TX_PAY;
        end
        aft_pkg::TX_PAY: if (ld) begin
          {tx_valid, tx_data} <= {1'b1, pay_b};
          csum_q <= csum_q + pay_b;
          idx_q <= idx_q + 8'h01;
          if (idx_q > aft_pkg::IX_STATUS) dsh_q <= {dsh_q[23:0], 8'h00};
          if (idx_q + 8'h01 == plen_q) st_q <= aft_pkg::TX_CSUM;
        end
        aft_pkg::TX_CSUM: if (ld) begin
          {tx_valid, tx_data} <= {1'b1, aft_pkg::CSUM_TOTAL - csum_q};
          st_q <= aft_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // interrupt status, write one to clear
  always_comb begin
    sts_set = '0;
    sts_set[aft_pkg::IB_AT_REQ] = at_commit;
    sts_set[aft_pkg::IB_ROUTE_OK] = rt_commit && !rt_bad;
    sts_set[aft_pkg::IB_ROUTE_DROP] = rt_commit && rt_bad;
    sts_set[aft_pkg::IB_CSUM_ERR] = rxb.frame_end && !rxb.frame_ok;
    sts_set[aft_pkg::IB_TX_DONE] = st_q == aft_pkg::TX_CSUM && ld;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      irq <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~((do_wr && wa == aft_pkg::A_IRQ_STS) ?
                wd[IRQ_W_L-1:0] : '0)) | sts_set;
      irq <= |(sts_q & mask_q);
    end
  end

  // axi read channel
  always_comb begin
    rd_d = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      aft_pkg::A_IRQ_STS: rd_d[IRQ_W_L-1:0] = sts_q;
      aft_pkg::A_IRQ_MASK: rd_d[IRQ_W_L-1:0] = mask_q;
      aft_pkg::A_REQ_INFO: rd_d = {5'h00, req_pend_q, req_que_q, req_has_par_q,
                                   req_c1_q, req_c0_q, req_fid_q};
      aft_pkg::A_REQ_PARAM: rd_d = req_par_q;
      aft_pkg::A_RESP: rd_d = {23'h000000, rsp_pend_q, 1'b0, rsp_more_q,
                               rsp_len_q, rsp_st_q};
      aft_pkg::A_RESP_DATA: rd_d = rsp_data_q;
      aft_pkg::A_MSTAT: rd_d = {23'h000000, mst_pend_q, mst_code_q};
      aft_pkg::A_ROUTE: rd_d = {7'h00, rt_vld_q, rt_dst_q, rt_cnt_q};
      aft_pkg::A_HOP: rd_d = {12'h000, hop_sel_q, hop_rd};
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= aft_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_ok ? aft_pkg::RESP_OKAY : aft_pkg::RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_delim_first: assert property (
    st_q == aft_pkg::TX_DELIM && ld |=> tx_valid && tx_data == 8'h7e)
    else $error("frame does not start with delimiter");
  a_csum_byte: assert property (
    st_q == aft_pkg::TX_CSUM && ld |=> tx_data == 8'hff - $past(csum_q))
    else $error("wrong outgoing checksum");
  a_rsp_type: assert property (
    st_q == aft_pkg::TX_PAY && ld && !kind_q && idx_q == 8'h00
    |=> tx_data == 8'h88) else $error("response type wrong");
  a_rsp_fid: assert property (
    st_q == aft_pkg::TX_PAY && ld && !kind_q && idx_q == 8'h01
    |=> tx_data == $past(req_fid_q)) else $error("frame id not echoed");
  a_rsp_cmd: assert property (
    st_q == aft_pkg::TX_PAY && ld && !kind_q && idx_q == 8'h02
    |=> tx_data == $past(req_c0_q)) else $error("command name wrong");
  a_zero_fid_quiet: assert property (
    wr_resp && req_fid_q == 8'h00 && !rsp_pend_q |=> !rsp_pend_q)
    else $error("response queued for zero frame id");
  a_param_omit: assert property (
    tx_start && !mst_pend_q && req_has_par_q |=> plen_q == 8'h05)
    else $error("value returned for a write request");
  a_route_drop: assert property (
    rt_commit && rt_bad |=> !rt_vld_q ##1 sts_q[aft_pkg::IB_ROUTE_DROP])
    else $error("bad route kept");
  a_mstat_type: assert property (
    st_q == aft_pkg::TX_PAY && ld && kind_q && idx_q == 8'h00
    |=> tx_data == 8'h8a) else $error("status frame type wrong");
  c_route_ok: cover property (rt_commit && !rt_bad);
  c_rsp_sent: cover property (st_q == aft_pkg::TX_CSUM && ld && !kind_q);
  c_mstat_sent: cover property (st_q == aft_pkg::TX_CSUM && ld && kind_q);
  c_route_drop: cover property (rt_commit && rt_bad);
endmodule : aft_responder

// ---- hw/aft_rx_if.sv ----
// payload byte stream from the frame parser to the responder
interface aft_rx_if;
  logic pay_valid;
  logic [7:0] pay_byte;
  logic [7:0] pay_idx;
  logic frame_end;
  logic frame_ok;
  modport src (output pay_valid, pay_byte, pay_idx, frame_end, frame_ok);
  modport dst (input pay_valid, pay_byte, pay_idx, frame_end, frame_ok);
endinterface : aft_rx_if

// ---- hw/aft_rx_parser.sv ----
// delimiter, length and checksum parser for incoming frames
module aft_rx_parser (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  aft_rx_if.src pb
);
  aft_pkg::aft_rx_st_t st_q;
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic [7:0] sum_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= aft_pkg::RX_IDLE;
      len_q <= 16'h0000;
      cnt_q <= 16'h0000;
      sum_q <= 8'h00;
      pb.pay_valid <= 1'b0;
      pb.pay_byte <= 8'h00;
      pb.pay_idx <= 8'h00;
      pb.frame_end <= 1'b0;
      pb.frame_ok <= 1'b0;
    end else begin
      pb.pay_valid <= 1'b0;
      pb.frame_end <= 1'b0;
      if (rx_valid) begin
        unique case (st_q)
          aft_pkg::RX_IDLE: begin
            if (rx_data == aft_pkg::DELIM) st_q <= aft_pkg::RX_LENH;
          end
          aft_pkg::RX_LENH: begin
            len_q <= {rx_data, 8'h00};
            st_q <= aft_pkg::RX_LENL;
          end
          aft_pkg::RX_LENL: begin
            len_q <= {len_q[15:8], rx_data};
            cnt_q <= 16'h0000;
            sum_q <= 8'h00;
            st_q <= ({len_q[15:8], rx_data} == 16'h0000) ?
                    aft_pkg::RX_CSUM : aft_pkg::RX_DATA;
          end
          aft_pkg::RX_DATA: begin
            pb.pay_valid <= 1'b1;
            pb.pay_byte <= rx_data;
            pb.pay_idx <= (cnt_q > 16'h00ff) ? 8'hff : cnt_q[7:0];
            sum_q <= sum_q + rx_data;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q + 16'h0001 == len_q) st_q <= aft_pkg::RX_CSUM;
          end
          aft_pkg::RX_CSUM: begin
            pb.frame_end <= 1'b1;
            pb.frame_ok <= (8'(sum_q + rx_data) ==
                            aft_pkg::CSUM_TOTAL);
            st_q <= aft_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end
endmodule : aft_rx_parser

// ---- testbench/aft_host.sv ----
// host model: frames bytes toward the block and collects its output
module aft_host (
  input wire logic aclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow = 1'b0;
  logic [7:0] rxq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // slow mode stalls the outgoing link every other cycle
  always @(posedge aclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) rxq.push_back(tx_data);
  end
  function automatic logic [7:0] sum(input logic [7:0] p[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (p[i]) s += p[i];
    return s;
  endfunction : sum
  typedef logic [7:0] aft_bq_t[$];
  function automatic aft_bq_t mk(input logic [7:0] p[$]);
    return {8'h7e, 8'(p.size() >> 8), 8'(p.size()), p,
            8'hff - sum(p)};
  endfunction : mk
  task send(input logic [7:0] p[$]);
    logic [7:0] f[$];
    f = mk(p);
    foreach (f[i]) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
endmodule : aft_host

// ---- testbench/api_frame_responder_tb.sv ----
// self-checking bench of the api frame responder
module api_frame_responder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic rx_valid, tx_valid, tx_ready, irq, awready, wready, bvalid;
  logic arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] rx_data, tx_data, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] hops[3] = '{16'heeff, 16'hccdd, 16'haabb};
  logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07,
    8'h0d, 8'h11, 8'h80};
  int num_errors = 0;
  int checks = 0;
  always #50 aclk = ~aclk;
  aft_host host (.aclk(aclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  aft_responder dut (.aclk(aclk), .aresetn(aresetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      $display("wrong value at %0t: %h expected %h", $time, s, e);
      num_errors++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  task expf(input logic [7:0] p[$]);
    logic [7:0] f[$];
    f = host.mk(p);
    for (int i = 0; i < 500 && host.rxq.size() < f.size(); i++)
      @(posedge aclk);
    chk(host.rxq.size(), f.size());
    while (host.rxq.size() > 0 && f.size() > 0)
      chk(host.rxq.pop_front(), f.pop_front());
    host.rxq = {};
  endtask : expf
  task wrap_up;
    $display("mismatches %0d of %0d checks", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    expf('{8'h8a, 8'h00});
    host.send('{8'h08, 8'h01, 8'h42, 8'h44});
    repeat (5) @(posedge aclk);
    rd(aft_pkg::A_REQ_INFO);
    chk(v, 32'h0444_4201);
    wr(aft_pkg::A_RESP_DATA, 32'h1234);
    wr(aft_pkg::A_RESP, 32'h10);
    expf('{8'h88, 8'h01, 8'h42, 8'h44, 8'h00,
      8'h12, 8'h34});
    host.send('{8'h09, 8'h02, 8'h42, 8'h44, 8'h03});
    repeat (5) @(posedge aclk);
    rd(aft_pkg::A_REQ_PARAM);
    chk(v, 32'h0000_0003);
    rd(aft_pkg::A_REQ_INFO);
    chk(v, 32'h0744_4202);
    for (int o = 0; o < 5; o++) begin
      wr(aft_pkg::A_RESP, o < 4 ? 32'h50 + o : 32'h10 + o);
      expf('{8'h88, 8'h02, 8'h42, 8'h44, 8'(o)});
    end
    host.send('{8'h08, 8'h00, 8'h42, 8'h44});
    repeat (5) @(posedge aclk);
    wr(aft_pkg::A_RESP, 32'h10);
    repeat (40) @(posedge aclk);
    chk(host.rxq.size(), 0);
    wr(aft_pkg::A_IRQ_MASK, 32'h2);
    chk(rs, aft_pkg::RESP_OKAY);
    wr(aft_pkg::A_IRQ_STS, 32'h1f);
    // hops listed from the destination side, fid zero
    host.send('{8'h21, 8'h00, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h40, 8'h40,
      8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h03, 8'hee, 8'hff, 8'hcc,
      8'hdd, 8'haa, 8'hbb});
    repeat (6) @(posedge aclk);
    chk(irq, 1'b1);
    rd(aft_pkg::A_ROUTE);
    chk(v, 32'h0133_4403);
    for (int h = 0; h < 3; h++) begin
      wr(aft_pkg::A_HOP, h);
      rd(aft_pkg::A_HOP);
      chk(v, {12'h0, 4'(h), hops[h]});
    end
    wr(aft_pkg::A_IRQ_STS, 32'h2);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    host.send('{8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h33, 8'h44, 8'h00, 8'h00});
    repeat (6) @(posedge aclk);
    rd(aft_pkg::A_ROUTE);
    chk(v[24], 1'b0);
    rd(aft_pkg::A_IRQ_STS);
    chk(v[2:1], 2'b10);
    wr(aft_pkg::A_IRQ_STS, 32'h4);
    host.send('{8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h33, 8'h44, 8'h00, 8'h0c});
    repeat (6) @(posedge aclk);
    rd(aft_pkg::A_IRQ_STS);
    chk(v[2:0], 3'b100);
    rd(8'h40);
    chk(rs, aft_pkg::RESP_DECERR);
    chk(v, 32'h0);
    wr(8'h40, 32'h1);
    chk(rs, aft_pkg::RESP_DECERR);
    host.slow <= 1'b1;
    foreach (codes[i]) begin
      wr(aft_pkg::A_MSTAT, codes[i]);
      expf('{8'h8a, codes[i]});
    end
    wrap_up;
  end
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    wrap_up;
  end
endmodule : api_frame_responder_tb
